// ---- design/cpes_regs.svh ----
/*
 Register offsets, field positions, reset values and event codes for the
 core performance event selector.
 Assumes inclusion once per compilation unit; guarded against repeats.
*/
`ifndef CPES_REGS_SVH
`define CPES_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CPES_SEL_OFFSET        8'h00
`define CPES_COUNT_LO_OFFSET   8'h04
`define CPES_COUNT_HI_OFFSET   8'h08
`define CPES_STATUS_OFFSET     8'h0c
`define CPES_IRQ_CLEAR_OFFSET  8'h10
`define CPES_IRQ_ENABLE_OFFSET 8'h14

// ----------------------------------------------------------------------
// Select register fields
// ----------------------------------------------------------------------
`define CPES_SEL_EVENT_LSB     0
`define CPES_SEL_UMASK_LSB     8
`define CPES_SEL_EDGE_BIT      16
`define CPES_SEL_ENABLE_BIT    17
`define CPES_SEL_INVERT_BIT    23
`define CPES_SEL_CMASK_LSB     24
`define CPES_SEL_RESET         32'h0000_0000

// ----------------------------------------------------------------------
// Status bits and reset values
// ----------------------------------------------------------------------
`define CPES_ST_WRAP_BIT       0
`define CPES_ST_UNDEF_BIT      1
`define CPES_IRQ_ENABLE_RESET  2'h0
`define CPES_COUNT_RESET       48'h0000_0000_0000

// ----------------------------------------------------------------------
// Event number and unit mask pairs
// ----------------------------------------------------------------------
`define CPES_EV_LOAD           8'h13
`define CPES_UM_LOAD_DELAYED   8'h02
`define CPES_UM_LOAD_ORDER     8'h04
`define CPES_UM_LOAD_ANY       8'h07
`define CPES_EV_ARITH          8'h14
`define CPES_UM_DIV_BUSY       8'h01
`define CPES_UM_MUL            8'h02
`define CPES_EV_IQ_WRITES      8'h17
`define CPES_EV_FIRST_DEC      8'h18
`define CPES_EV_DUAL_UOP       8'h19
`define CPES_EV_IQ_CYCLES      8'h1e
`define CPES_EV_LOOP_MISS      8'h20
`define CPES_UM_SINGLE         8'h01

`endif

// ---- design/cpes_pkg.sv ----
/*
 Types shared by the core performance event selector.
 Assumes the pipeline reports each condition as a per-cycle count.
*/
`default_nettype none

package cpes_pkg;

   // Per-cycle event counts from the pipeline; widths cover four lanes.
   typedef struct packed {
      logic [2:0] load_issue_staging_delayed;
      logic [2:0] load_issue_to_order_buffer;
      logic [2:0] load_issue_bypass;
      logic       divider_busy;
      logic [2:0] multiply_ops;
      logic [2:0] iq_write_count;
      logic [2:0] first_decoder_insts;
      logic [2:0] dual_microop_decodes;
      logic       loop_stream_miss;
   } cpes_events_type;

   typedef struct packed {
      logic [7:0] cmask;
      logic       invert;
      logic [4:0] rsvd;
      logic       enable;
      logic       edge_det;
      logic [7:0] umask;
      logic [7:0] event_num;
   } cpes_select_type;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } cpes_bus_req_type;

endpackage : cpes_pkg

`default_nettype wire

// ---- design/cpes_selector.sv ----
/*
 Performance event selector with one 48-bit counter and its qualifiers.
 Assumes a single-clock register port with read data one cycle after the
 read strobe, and event counts synchronous to clk_sys_i.
*/
// Operation
// - Pair 13h/02h counts loads reissued from the delayed staging latch.
// - Pair 13h/04h counts loads issued to the memory ordering buffer.
// - Pair 13h/07h counts every load issued from the reservation station.
// - Pair 14h/01h counts each cycle in which the divider is occupied.
// - Pair 14h/02h counts executed multiplies, as the source reports them.
// - Divider and multiply counts carry no exactness under multithreading.
// - Pair 17h/01h adds the instruction queue writes of each cycle.
// - Pair 18h/01h counts instructions that only the first decoder takes.
// - Pair 19h/01h counts decodes that produce exactly two micro-ops.
// - Pair 1Eh/01h counts cycles with at least one queue write.
// - Pair 20h/01h counts loops the loop stream detector cannot stream.
`default_nettype none
`include "cpes_regs.svh"

module cpes_selector #(
   parameter int COUNT_WIDTH = 48
) (
   input  wire logic                      clk_sys_i,
   input  wire logic                      rst_b_i,
   input  wire cpes_pkg::cpes_events_type events_i,
   input  wire logic [7:0]                addr_i,
   input  wire logic [31:0]               wdata_i,
   input  wire logic                      wr_i,
   input  wire logic                      rd_i,
   output logic      [31:0]               rdata_o,
   output logic                           irq_o
);
   import cpes_pkg::*;

   initial begin
      if (COUNT_WIDTH != 48) begin
         $error("cpes_selector: COUNT_WIDTH must be 48");
      end
   end

   // ----------------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------------
   function automatic logic is_addr(input logic [7:0] a,
                                    input logic [7:0] off);
      is_addr = (a == off);
   endfunction : is_addr

   cpes_select_type  sel;
   logic [47:0]      count;
   logic [1:0]       status;
   logic [1:0]       irq_enable;
   logic [4:0]       raw_inc;
   logic             pair_known;
   logic             over_thresh;
   logic             qual;
   logic             qual_prev;
   logic [4:0]       next_inc;
   logic [47:0]      next_count;
   logic             wrap;

   // ----------------------------------------------------------------------
   // Event mux
   // ----------------------------------------------------------------------
   always_comb begin
      raw_inc    = 5'h00;
      pair_known = 1'b1;
      unique case ({sel.event_num, sel.umask})
         {`CPES_EV_LOAD, `CPES_UM_LOAD_DELAYED}:
            raw_inc = {2'b00, events_i.load_issue_staging_delayed};
         {`CPES_EV_LOAD, `CPES_UM_LOAD_ORDER}:
            raw_inc = {2'b00, events_i.load_issue_to_order_buffer};
         {`CPES_EV_LOAD, `CPES_UM_LOAD_ANY}:
            // Three 3-bit counts can reach 21, so the sum needs 5 bits.
            raw_inc = 5'({2'b00, events_i.load_issue_staging_delayed}
                       + {2'b00, events_i.load_issue_to_order_buffer}
                       + {2'b00, events_i.load_issue_bypass});
         {`CPES_EV_ARITH, `CPES_UM_DIV_BUSY}:
            // Counts are taken as reported; with two threads sharing the
            // divider the attribution is not exact.
            raw_inc = {4'h0, events_i.divider_busy};
         {`CPES_EV_ARITH, `CPES_UM_MUL}:
            raw_inc = {2'b00, events_i.multiply_ops};
         {`CPES_EV_IQ_WRITES, `CPES_UM_SINGLE}:
            raw_inc = {2'b00, events_i.iq_write_count};
         {`CPES_EV_FIRST_DEC, `CPES_UM_SINGLE}:
            raw_inc = {2'b00, events_i.first_decoder_insts};
         {`CPES_EV_DUAL_UOP, `CPES_UM_SINGLE}:
            raw_inc = {2'b00, events_i.dual_microop_decodes};
         {`CPES_EV_IQ_CYCLES, `CPES_UM_SINGLE}:
            raw_inc = {4'h0, (events_i.iq_write_count != 3'h0)};
         {`CPES_EV_LOOP_MISS, `CPES_UM_SINGLE}:
            raw_inc = {4'h0, events_i.loop_stream_miss};
         default: begin
            raw_inc    = 5'h00;
            pair_known = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Qualifiers
   // ----------------------------------------------------------------------
   // With a nonzero threshold the per-cycle count becomes a one-bit
   // condition; invert and edge then let software count divide completions.
   always_comb begin
      over_thresh = ({3'h0, raw_inc} >= sel.cmask);
      qual        = sel.invert ? !over_thresh : over_thresh;
      if (sel.cmask == 8'h00) begin
         next_inc = raw_inc;
      end else if (sel.edge_det) begin
         next_inc = {4'h0, qual && !qual_prev};
      end else begin
         next_inc = {4'h0, qual};
      end
      if (!sel.enable) begin
         next_inc = 5'h00;
      end
      next_count = count + {43'h0, next_inc};
      wrap       = sel.enable && (next_count < count);
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         qual_prev <= 1'b0;
      end else begin
         qual_prev <= qual;
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         sel <= cpes_select_type'(`CPES_SEL_RESET);
      end else if (wr_i && is_addr(addr_i, `CPES_SEL_OFFSET)) begin
         sel      <= cpes_select_type'(wdata_i);
         sel.rsvd <= 5'h00;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         count <= `CPES_COUNT_RESET;
      end else if (wr_i && is_addr(addr_i, `CPES_COUNT_LO_OFFSET)) begin
         count[31:0] <= wdata_i;
      end else if (wr_i && is_addr(addr_i, `CPES_COUNT_HI_OFFSET)) begin
         count[47:32] <= wdata_i[15:0];
      end else begin
         count <= next_count;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         irq_enable <= `CPES_IRQ_ENABLE_RESET;
      end else if (wr_i && is_addr(addr_i, `CPES_IRQ_ENABLE_OFFSET)) begin
         irq_enable <= wdata_i[1:0];
      end
   end

   // A new event wins over a clear written in the same cycle.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         status <= 2'h0;
      end else begin
         if (wr_i && is_addr(addr_i, `CPES_IRQ_CLEAR_OFFSET)) begin
            status <= status & ~wdata_i[1:0];
         end
         if (wrap) begin
            status[`CPES_ST_WRAP_BIT] <= 1'b1;
         end
         if (sel.enable && !pair_known) begin
            status[`CPES_ST_UNDEF_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (rd_i) begin
         unique case (addr_i)
            `CPES_SEL_OFFSET:        rdata_o <= 32'(sel);
            `CPES_COUNT_LO_OFFSET:   rdata_o <= count[31:0];
            `CPES_COUNT_HI_OFFSET:   rdata_o <= {16'h0000, count[47:32]};
            `CPES_STATUS_OFFSET:     rdata_o <= {30'h0, status};
            `CPES_IRQ_ENABLE_OFFSET: rdata_o <= {30'h0, irq_enable};
            default:                 rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         rdata_o <= 32'h0000_0000;
      end
   end

   assign irq_o = |(status & irq_enable);

endmodule : cpes_selector

`default_nettype wire

// ---- sim/cpes_properties.sv ----
/*
 Port checker for the performance event selector.
 Assumes it is bound to cpes_selector and sees only its ports.
*/
`default_nettype none
module cpes_properties (
   input wire logic        clk_sys_i,
   input wire logic        rst_b_i,
   input wire logic [7:0]  addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic        irq_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   // --------------------------------------------------------------
   // Register port
   // --------------------------------------------------------------
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside its slot");
   a_clear_reads_zero: assert property (rd_i && addr_i == 8'h10 |=>
      rdata_o == 32'h0) else $error("clear register read back");
   a_unmapped_zero: assert property (rd_i && addr_i == 8'h20 |=>
      rdata_o == 32'h0) else $error("unmapped read not zero");
   a_sel_field_width: assert property (rd_i && addr_i == 8'h00 |=>
      rdata_o[22:18] == 5'h0) else $error("select spare bits set");
   a_hi_count_width: assert property (rd_i && addr_i == 8'h08 |=>
      rdata_o[31:16] == 16'h0) else $error("counter above 48 bits");
   a_status_bits_two: assert property (rd_i && addr_i == 8'h0c |=>
      rdata_o[31:2] == 30'h0) else $error("status spare bits set");
   // --------------------------------------------------------------
   // Interrupt and coverage
   // --------------------------------------------------------------
   a_irq_after_reset: assert property ($rose(rst_b_i) |-> !irq_o)
      else $error("interrupt high after reset");
   a_irq_mask_off: assert property (wr_i && addr_i == 8'h14 &&
      wdata_i[1:0] == 2'h0 |=> !irq_o [*2]) else $error("masked irq");
   c_read_low: cover property (rd_i && addr_i == 8'h04);
   c_irq_rise: cover property ($rose(irq_o));
   c_sel_write: cover property (wr_i && addr_i == 8'h00);
endmodule : cpes_properties
bind cpes_selector cpes_properties chk_u (.clk_sys_i(clk_sys_i),
   .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
`default_nettype wire

// ---- sim/cpes_event_src.sv ----
/*
 Pipeline event source: random per-cycle counts while active.
 Assumes act_i changes just after a rising edge.
*/
`default_nettype none
module cpes_event_src (
   input  wire logic                clk_sys_i,
   input  wire logic                act_i,
   output var cpes_pkg::cpes_events_type ev_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import cpes_pkg::*;
   int seed = 61277;
   // Zero when idle so that idle time adds nothing to any count whose qualifier is not inverted.
   initial ev_o = '0;
   always @(posedge clk_sys_i)
      ev_o <= act_i ? cpes_events_type'(23'($random(seed))) : '0;
endmodule : cpes_event_src
`default_nettype wire

// ---- sim/tb.sv ----
/*
 Self-checking bench for the performance event selector.
 Assumes the selector answers reads one cycle after the strobe.
*/
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cpes_pkg::*;
   logic clk_sys_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic act = 1'b0, rd_d = 1'b0, irq_o, qp = 1'b0;
   logic [7:0] addr_i = 8'h0;
   logic [31:0] wdata_i = 32'h0, rdata_o, cur_sel = 32'h0;
   logic [47:0] exp = 48'h0, base;
   logic [31:0] exp_q[$];
   // The 0183_0114 entry is the divide-count setting: edge, invert,
   // threshold one on the divider-busy event.
   logic [31:0] sels[13] = '{32'h0002_0213, 32'h0002_0413, 32'h0002_0713,
      32'h0002_0114, 32'h0002_0214, 32'h0002_0117, 32'h0002_0118,
      32'h0002_0119, 32'h0002_011e, 32'h0002_0120, 32'h0202_0117,
      32'h0183_0114, 32'h0002_0113};
   int err_total = 0, checks_done = 0;
   cpes_events_type ev;
   cpes_event_src src_u (.clk_sys_i(clk_sys_i), .act_i(act), .ev_o(ev));
   cpes_selector dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .events_i(ev), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
   always #20 clk_sys_i = ~clk_sys_i;
   // --------------------------------------------------------------
   // Expected count per cycle for a select value
   // --------------------------------------------------------------
   function automatic logic [47:0] inc(logic [31:0] s, cpes_events_type e);
      logic [47:0] r;
      r = 48'h0;
      case (s[15:0])
         16'h0213: r = 48'(e.load_issue_staging_delayed);
         16'h0413: r = 48'(e.load_issue_to_order_buffer);
         16'h0713: r = 48'(e.load_issue_staging_delayed)
            + 48'(e.load_issue_bypass)
            + 48'(e.load_issue_to_order_buffer);
         16'h0114: r = 48'(e.divider_busy);
         16'h0214: r = 48'(e.multiply_ops);
         16'h0117: r = 48'(e.iq_write_count);
         16'h0118: r = 48'(e.first_decoder_insts);
         16'h0119: r = 48'(e.dual_microop_decodes);
         16'h011e: r = 48'(e.iq_write_count != 3'h0);
         16'h0120: r = 48'(e.loop_stream_miss);
         default: r = 48'h0;
      endcase
      return r;
   endfunction : inc
   function automatic logic q_of(logic [31:0] s, cpes_events_type e);
      return (inc(s, e) >= 48'(s[31:24])) ^ s[23];
   endfunction : q_of
   always @(posedge clk_sys_i) begin
      if (cur_sel[31:24] == 8'h0) exp <= exp + inc(cur_sel, ev);
      else if (cur_sel[16]) exp <= exp + 48'(q_of(cur_sel, ev) && !qp);
      else exp <= exp + 48'(q_of(cur_sel, ev));
      qp <= q_of(cur_sel, ev);
   end
   always @(posedge clk_sys_i) rd_d <= rd_i;
   always @(negedge clk_sys_i) if (rd_d) chk(rdata_o, exp_q.pop_front());
   // --------------------------------------------------------------
   // Bus tasks and checks
   // --------------------------------------------------------------
   task automatic chk(logic [31:0] s, logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("ERROR %0t got %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic wr(logic [7:0] a, logic [31:0] d);
      addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
      @(posedge clk_sys_i) wr_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask : wr
   task automatic rd(logic [7:0] a, logic [31:0] e);
      addr_i <= a; rd_i <= 1'b1; exp_q.push_back(e);
      @(posedge clk_sys_i) rd_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask : rd
   task automatic conclude;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   initial begin
      #200000 err_total++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      @(posedge clk_sys_i);
      foreach (sels[i]) begin
         base = exp; cur_sel = sels[i];
         wr(8'h00, sels[i]);
         act <= 1'b1;
         repeat (20) @(posedge clk_sys_i);
         act <= 1'b0;
         @(posedge clk_sys_i);
         wr(8'h00, 32'h0); cur_sel = 32'h0;
         rd(8'h04, 32'(exp - base));
         rd(8'h08, {16'h0, 16'((exp - base) >> 32)});
         wr(8'h04, 32'h0); wr(8'h08, 32'h0);
      end
      wr(8'h00, 32'hffff_ffff); rd(8'h00, 32'hff83_ffff);
      wr(8'h00, 32'h0); rd(8'h0c, 32'h2); chk(32'(irq_o), 32'h0);
      wr(8'h14, 32'h3); chk(32'(irq_o), 32'h1);
      wr(8'h14, 32'h0); chk(32'(irq_o), 32'h0);
      wr(8'h14, 32'h2); wr(8'h10, 32'h2); rd(8'h0c, 32'h0);
      chk(32'(irq_o), 32'h0); rd(8'h10, 32'h0); rd(8'h20, 32'h0);
      @(posedge clk_sys_i);
      conclude();
   end
endmodule : tb
`default_nettype wire
